//--- logic/bias_supervisor_pkg.sv
// bias supply supervisor package: constants, states, carriers
// assumes a 125 MHz mclk and synchronous comparator inputs
`default_nettype none
package bias_supervisor_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned GATE_TIMEOUT_MS  = 15;
  localparam int unsigned GATE_TIMEOUT_CYC = GATE_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned STANDBY_DELAY_MS = 1;
  localparam int unsigned STANDBY_CYC      = STANDBY_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned FILT_LEN         = 4;
  localparam int unsigned CNT_W            = 24;
  // register offsets (word addresses on the plain port)
  localparam logic [3:0] ADDR_STATUS0 = 4'h0;
  localparam logic [3:0] ADDR_STATUS1 = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h3;
  localparam logic [3:0] ADDR_CTRL    = 4'h4;
  localparam logic [3:0] ADDR_STATE   = 4'h5;
  // status0 bits
  localparam int unsigned B_OT   = 2;
  localparam int unsigned B_UV   = 3;
  localparam int unsigned B_OV   = 4;
  // status1 bits
  localparam int unsigned B_HRUV = 0;
  localparam int unsigned B_COL  = 1;
  // message codes on the link request
  localparam logic [7:0] MSG_STAT0 = 8'h85;
  localparam logic [7:0] MSG_SECOND_STATUS_REGISTER = 8'h86;
  localparam logic [7:0] BIT_OT    = 8'h04;
  localparam logic [7:0] BIT_WARN  = 8'h02;
  localparam logic [7:0] BIT_UV    = 8'h08;
  localparam logic [7:0] BIT_OV    = 8'h10;
  localparam logic [7:0] BIT_HRUV  = 8'h01;
  localparam logic [7:0] BIT_COL   = 8'h02;
  // irq bits
  localparam int unsigned IRQ_W  = 6;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

  typedef enum logic [5:0] {
    ST_POR     = 6'h01,
    ST_STANDBY = 6'h02,
    ST_GATE    = 6'h04,
    ST_ACTIVE  = 6'h08,
    ST_SLEEP   = 6'h10,
    ST_COLLAPSE= 6'h20
  } mode_type;

  typedef struct packed {
    logic supply_below_pump_start;
    logic supply_above_pump_stop;
    logic gate_bias_above_ready;
    logic host_rail_low;
    logic supply_low_lockout;
    logic supply_high_lockout;
    logic supply_collapse;
    logic supply_above_release;
    logic over_temp;
    logic temp_below_hyst;
    logic temp_warn;
  } sense_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] bits;
  } link_msg_type;
endpackage : bias_supervisor_pkg
`default_nettype wire

//--- logic/bias_supply_supervisor.sv
// bias supply supervisor: pump, gate bias rail, host ldo and faults
// assumes comparator levels synchronous to mclk, a link serialiser
// that accepts one message per msg_ack pulse
//
// Behaviour
// - pump on below start, bypass above 13.5V
// - gate bias ready flag once rail rises
// - leave gate bias state after 15 ms
// - gate bias rail off in standby/sleep
// - host rail low sets flag, ldo runs
// - ldo off on supply undervoltage, recovers
// - sleep keeps ldo off, pulled low
// - lockouts stop drivers, pump, bias rail
// - supervisor failures drive fault, send message
// - collapse outside sleep shuts all, flags, ldo pulled low
// - collapse latched until release threshold
// - overtemp stops drivers, pump, bias rail; ldo and messaging run
// - after overtemp message, oe low stops messaging
// - resume after cool and oe rising edge
// - thermal warning sends message only
// - oe rise clears only ceased faults
//
// Our own choices: the register offsets and the address-and-strobe port.
`default_nettype none
module bias_supply_supervisor
  import bias_supervisor_pkg::*;
#(
  parameter int unsigned GATE_TIMEOUT = GATE_TIMEOUT_CYC,
  parameter int unsigned STANDBY_WAIT = STANDBY_CYC
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire sense_type    sense,
  input  wire logic         oe_pin,
  input  wire logic         sleep_request,
  input  wire logic         wake_event,
  input  wire reg_req_type  reg_req,
  output logic [7:0]        reg_rdata,
  output link_msg_type      msg,
  input  wire logic         msg_ack,
  output logic              pump_enable,
  output logic              gate_bias_enable,
  output logic              gate_bias_ready_flag,
  output logic              drivers_enable,
  output logic              host_ldo_enable,
  output logic              host_ldo_pulldown,
  output logic              messaging_enable,
  output logic              fault_pin_out,
  output logic              fault_pin_oe_n,
  output logic              irq
);
  // counters must hold the longest wait
  if (GATE_TIMEOUT < 1 || GATE_TIMEOUT >= (1 << CNT_W) ||
      STANDBY_WAIT < 1 || STANDBY_WAIT >= (1 << CNT_W)) begin : g_bad_cnt
    $error("counter parameters out of range");
  end

  localparam int unsigned NS = $bits(sense_type);

  ////////////////////////////////////////////////////////////////////////
  // one glitch filter per comparator level
  logic [NS-1:0] filt;

  for (genvar i = 0; i < NS; i++) begin : g_filt
    level_filter #(
      .LEN (FILT_LEN)
    ) u_level_filter (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .raw     (sense[i]),
      .level   (filt[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    mode_type                   mode;
    logic [CNT_W-1:0]           cnt;
    logic                       oe_q;
    logic [7:0]                 stat0;
    logic [7:0]                 second_status_register;
    logic                       warn_sent;
    logic [IRQ_W-1:0]           irq_st;
    logic [IRQ_W-1:0]           irq_msk;
    logic [7:0]                 rdata;
    link_msg_type               msg;
    logic [2:0]                 pend;
    logic                       ot_msg_done;
    logic                       pump;
    logic                       gbias;
    logic                       gready;
    logic                       drv;
    logic                       ldo;
    logic                       pull;
    logic                       msgen;
    logic                       fault;
    logic                       irq;
  } state_type;

  // reset: por mode, fault pin low, all enables off
  localparam state_type ST_RST = '{
    mode:    ST_POR,
    irq_st:  IRQ_RST,
    irq_msk: IRQ_RST,
    fault:   1'b1,
    default: '0
  };

  state_type st_ff;
  state_type nxt_st;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    sense_type f;
    logic oe_rise;
    logic any_fault;
    logic [IRQ_W-1:0] ev;
    f = sense_type'(filt);
    oe_rise = 1'b0;
    any_fault = 1'b0;
    ev = '0;
    nxt_st = st_ff;
    nxt_st.oe_q = oe_pin;
    oe_rise = oe_pin & ~st_ff.oe_q;

    // fault latches, set wins over clear
    if (oe_rise) begin
      if (!f.over_temp && f.temp_below_hyst) nxt_st.stat0[B_OT] = 1'b0;
      if (!f.supply_low_lockout) nxt_st.stat0[B_UV] = 1'b0;
      if (!f.supply_high_lockout) nxt_st.stat0[B_OV] = 1'b0;
      if (!f.host_rail_low) nxt_st.second_status_register[B_HRUV] = 1'b0;
    end
    if (f.over_temp && !st_ff.stat0[B_OT]) begin
      nxt_st.stat0[B_OT] = 1'b1;
      nxt_st.pend[0] = 1'b1;
      nxt_st.ot_msg_done = 1'b0;
      ev[0] = 1'b1;
    end
    if (f.supply_low_lockout && !st_ff.stat0[B_UV]) begin
      nxt_st.stat0[B_UV] = 1'b1;
      nxt_st.pend[1] = 1'b1;
      ev[1] = 1'b1;
    end
    if (f.supply_high_lockout && !st_ff.stat0[B_OV]) begin
      nxt_st.stat0[B_OV] = 1'b1;
      nxt_st.pend[1] = 1'b1;
      ev[2] = 1'b1;
    end
    if (f.host_rail_low && !st_ff.second_status_register[B_HRUV]) begin
      nxt_st.second_status_register[B_HRUV] = 1'b1;
      nxt_st.pend[2] = 1'b1;
      ev[3] = 1'b1;
    end
    if (f.temp_warn && !st_ff.warn_sent) begin
      nxt_st.warn_sent = 1'b1;
      nxt_st.pend[0] = 1'b1;
      ev[4] = 1'b1;
    end
    if (!f.temp_warn) nxt_st.warn_sent = 1'b0;
    nxt_st.stat0[1] = f.temp_warn;
    any_fault = |{nxt_st.stat0[B_OV:B_OT], nxt_st.second_status_register[B_COL:B_HRUV]};
    nxt_st.stat0[0] = any_fault;

    // message sender: one message at a time
    if (st_ff.msg.valid) begin
      if (msg_ack) begin
        nxt_st.msg.valid = 1'b0;
        if (st_ff.msg.code == MSG_STAT0 && st_ff.stat0[B_OT])
          nxt_st.ot_msg_done = 1'b1;
      end
    end else if (st_ff.msgen && |st_ff.pend) begin
      nxt_st.msg.valid = 1'b1;
      if (st_ff.pend[0] || st_ff.pend[1]) begin
        nxt_st.msg.code = MSG_STAT0;
        nxt_st.msg.bits = st_ff.stat0;
        nxt_st.pend[1:0] = 2'b00;
      end else begin
        nxt_st.msg.code = MSG_SECOND_STATUS_REGISTER;
        nxt_st.msg.bits = st_ff.second_status_register;
        nxt_st.pend[2] = 1'b0;
      end
    end

    // mode sequencer
    nxt_st.cnt = st_ff.cnt + 1'b1;
    case (st_ff.mode)
      ST_POR: begin
        nxt_st.ldo = 1'b1;
        nxt_st.pull = 1'b0;
        nxt_st.msgen = 1'b1;
        nxt_st.cnt = '0;
        if (!f.supply_collapse) nxt_st.mode = ST_STANDBY;
      end
      ST_STANDBY: begin
        nxt_st.cnt = '0;
        // cooled overtemp latch clears on this same oe edge
        if (oe_rise && !nxt_st.stat0[B_OT]) nxt_st.mode = ST_GATE;
        else if (!oe_pin && sleep_request) nxt_st.mode = ST_SLEEP;
      end
      ST_GATE: begin
        if (f.gate_bias_above_ready || st_ff.cnt >= CNT_W'(GATE_TIMEOUT - 1))
          nxt_st.mode = ST_ACTIVE;
        if (!oe_pin) begin
          nxt_st.mode = ST_ACTIVE;
          nxt_st.cnt = '0;
        end
      end
      ST_ACTIVE: begin
        if (oe_pin) nxt_st.cnt = '0;
        else if (st_ff.cnt >= CNT_W'(STANDBY_WAIT - 1))
          nxt_st.mode = sleep_request ? ST_SLEEP : ST_STANDBY;
        // overtemp resume needs a set, cooled latch and oe edge
        if (oe_rise && st_ff.stat0[B_OT] &&
            f.temp_below_hyst && !f.over_temp)
          nxt_st.mode = ST_GATE;
      end
      ST_SLEEP: begin
        nxt_st.ldo = 1'b0;
        nxt_st.pull = 1'b1;
        nxt_st.msgen = 1'b0;
        if (wake_event) nxt_st.mode = ST_POR;
      end
      ST_COLLAPSE: begin
        if (f.supply_above_release) nxt_st.mode = ST_POR;
      end
      default: nxt_st.mode = ST_POR;
    endcase
    if (f.supply_collapse && st_ff.mode != ST_SLEEP) begin
      nxt_st.mode = ST_COLLAPSE;
      if (!st_ff.second_status_register[B_COL]) ev[5] = 1'b1;
      nxt_st.second_status_register[B_COL] = 1'b1;
      nxt_st.ldo = 1'b0;
      nxt_st.pull = 1'b1;
      nxt_st.msgen = 1'b0;
      nxt_st.msg.valid = 1'b0;
    end
    if (st_ff.mode == ST_COLLAPSE && nxt_st.mode == ST_POR)
      nxt_st.second_status_register[B_COL] = 1'b0;
    if (f.supply_low_lockout && st_ff.mode != ST_COLLAPSE &&
        st_ff.mode != ST_SLEEP)
      nxt_st.ldo = 1'b0;
    else if (st_ff.mode == ST_STANDBY || st_ff.mode == ST_GATE ||
             st_ff.mode == ST_ACTIVE) begin
      nxt_st.ldo = 1'b1;
      nxt_st.pull = 1'b0;
    end
    if (st_ff.stat0[B_OT] && st_ff.ot_msg_done && !oe_pin)
      nxt_st.msgen = 1'b0;
    else if (st_ff.mode != ST_SLEEP && st_ff.mode != ST_COLLAPSE &&
             !f.supply_collapse)
      nxt_st.msgen = 1'b1;

    // rail enables
    nxt_st.gbias = (nxt_st.mode == ST_GATE || nxt_st.mode == ST_ACTIVE) &&
                   (oe_pin || nxt_st.mode == ST_ACTIVE);
    nxt_st.drv = nxt_st.mode == ST_ACTIVE && oe_pin;
    if (nxt_st.stat0[B_UV] || nxt_st.stat0[B_OV] ||
        nxt_st.second_status_register[B_HRUV] || nxt_st.stat0[B_OT]) begin
      nxt_st.gbias = 1'b0;
      nxt_st.drv = 1'b0;
    end
    if (nxt_st.mode == ST_STANDBY || nxt_st.mode == ST_SLEEP ||
        nxt_st.mode == ST_COLLAPSE || nxt_st.mode == ST_POR)
      nxt_st.gbias = 1'b0;
    if (f.supply_above_pump_stop) nxt_st.pump = 1'b0;
    else if (f.supply_below_pump_start) nxt_st.pump = 1'b1;
    if (!nxt_st.gbias) nxt_st.pump = 1'b0;
    nxt_st.gready = nxt_st.gbias && f.gate_bias_above_ready;
    nxt_st.fault = any_fault || st_ff.mode == ST_POR;

    // register port
    nxt_st.rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_STATUS0: nxt_st.rdata = st_ff.stat0;
        ADDR_STATUS1: nxt_st.rdata = st_ff.second_status_register;
        ADDR_IRQ_ST:  nxt_st.rdata = {2'b00, st_ff.irq_st};
        ADDR_IRQ_MSK: nxt_st.rdata = {2'b00, st_ff.irq_msk};
        ADDR_CTRL:    nxt_st.rdata = {7'h00, st_ff.gready};
        ADDR_STATE:   nxt_st.rdata = {2'b00, st_ff.mode};
        default:      nxt_st.rdata = 8'h00;
      endcase
    end
    if (reg_req.wr && reg_req.addr == ADDR_IRQ_MSK)
      nxt_st.irq_msk = reg_req.wdata[IRQ_W-1:0];
    if (reg_req.wr && reg_req.addr == ADDR_IRQ_ST)
      nxt_st.irq_st = st_ff.irq_st & ~reg_req.wdata[IRQ_W-1:0];
    nxt_st.irq_st = nxt_st.irq_st | ev;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_msk);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata            = st_ff.rdata;
  assign msg                  = st_ff.msg;
  assign pump_enable          = st_ff.pump;
  assign gate_bias_enable     = st_ff.gbias;
  assign gate_bias_ready_flag = st_ff.gready;
  assign drivers_enable       = st_ff.drv;
  assign host_ldo_enable      = st_ff.ldo;
  assign host_ldo_pulldown    = st_ff.pull;
  assign messaging_enable     = st_ff.msgen;
  assign fault_pin_out        = 1'b0;
  assign fault_pin_oe_n       = ~st_ff.fault;
  assign irq                  = st_ff.irq;
endmodule // bias_supply_supervisor

////////////////////////////////////////////////////////////////////////
// level filter: output follows input after LEN equal samples
module level_filter
  import bias_supervisor_pkg::*;
#(
  parameter int unsigned LEN = FILT_LEN
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic raw,
  output logic      level
);
  if (LEN < 2) begin : g_bad_len
    $error("filter length below two");
  end

  typedef struct packed {
    logic [LEN-1:0] shr;
    logic           level;
  } filt_state_type;

  filt_state_type st_ff;
  filt_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.shr = {st_ff.shr[LEN-2:0], raw};
    // mixed samples keep the old level
    if (&st_ff.shr) begin
      nxt_st.level = 1'b1;
    end else if (~|st_ff.shr) begin
      nxt_st.level = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.level;
endmodule // level_filter
`default_nettype wire

//--- test/bias_supply_supervisor_properties.sv
// checker: port relations of the bias supply supervisor
// assumes bind onto the top; raw sense inputs pass a 4-sample filter
`default_nettype none
module bias_supply_supervisor_properties
  import bias_supervisor_pkg::*;
#(
  parameter int unsigned GATE_TIMEOUT = 20,
  parameter int unsigned STANDBY_WAIT = 10
) (
  input wire logic         mclk,
  input wire logic         sys_rst,
  input wire sense_type    sense,
  input wire link_msg_type msg,
  input wire logic         msg_ack,
  input wire logic         pump_enable,
  input wire logic         gate_bias_enable,
  input wire logic         gate_bias_ready_flag,
  input wire logic         drivers_enable,
  input wire logic         host_ldo_enable,
  input wire logic         host_ldo_pulldown,
  input wire logic         fault_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic lock;
  assign lock = sense.supply_low_lockout | sense.supply_high_lockout
              | sense.host_rail_low;
  ////////////////////////////////////////////////////////////////////////
  pump_bypass_a: assert property (sense.supply_above_pump_stop [*8]
    |-> !pump_enable) else $error("pump on above stop");
  ready_cause_a: assert property ($rose(gate_bias_ready_flag)
    |-> $past(sense.gate_bias_above_ready)) else $error("bad ready");
  sleep_bias_a: assert property (host_ldo_pulldown
    |-> !gate_bias_enable) else $error("bias on in sleep");
  ldo_pulled_a: assert property (host_ldo_pulldown
    |-> !host_ldo_enable) else $error("ldo on while pulled");
  uv_ldo_off_a: assert property (sense.supply_low_lockout [*8]
    |-> !host_ldo_enable) else $error("ldo on in uv");
  lockout_stop_a: assert property (lock [*8] |-> !drivers_enable
    && !pump_enable && !gate_bias_enable) else $error("lockout");
  fault_pin_a: assert property (lock [*8]
    |-> !fault_pin_oe_n) else $error("fault pin idle");
  msg_hold_a: assert property (msg.valid && !msg_ack |=> msg.valid
    && $stable(msg.code) && $stable(msg.bits)) else $error("msg");
  collapse_off_a: assert property (sense.supply_collapse [*8]
    |-> host_ldo_pulldown && !drivers_enable) else $error("col");
  ot_stop_a: assert property (sense.over_temp [*8] |-> !drivers_enable
    && !gate_bias_enable) else $error("ot drivers on");
  cover property (msg.valid && msg_ack);
  cover property ($fell(drivers_enable));
  cover property (sense.supply_collapse ##1 host_ldo_pulldown);
endmodule // bias_supply_supervisor_properties
`default_nettype wire

//--- test/bias_supply_supervisor_tb_top.sv
// bench: sequencing, fault table, sticky faults, sleep, collapse
// assumes short counts GATE_TIMEOUT 20, STANDBY_WAIT 10
`default_nettype none
module bias_supply_supervisor_tb_top;
  import bias_supervisor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] BASE = 11'h50A;
  typedef struct packed {
    logic [10:0] s; logic [4:0] o; logic [7:0] s0, s1, c, b;
  } row_type;
  logic         mclk, sys_rst, oe_pin, sleep_request, wake_event, msg_ack;
  sense_type    sense;
  reg_req_type  reg_req;
  link_msg_type msg;
  logic [7:0]   reg_rdata, last_code, last_bits, msg_cnt, n;
  logic         pump_enable, gate_bias_enable, gate_bias_ready_flag, irq;
  logic         drivers_enable, host_ldo_enable, host_ldo_pulldown;
  logic         messaging_enable, fault_pin_out, fault_pin_oe_n, fault_line;
  logic         pwm_allowed;
  row_type      rows [5];
  int           mismatches = 0;
  int           cmp_count = 0;
  assign fault_line = fault_pin_oe_n ? 1'b1 : fault_pin_out;
  always #4 mclk = ~mclk;
  bias_supply_supervisor #(.GATE_TIMEOUT(20), .STANDBY_WAIT(10))
    u_bias_supply_supervisor (
    .mclk(mclk), .sys_rst(sys_rst), .sense(sense), .oe_pin(oe_pin),
    .sleep_request(sleep_request), .wake_event(wake_event),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .msg(msg), .msg_ack(msg_ack),
    .pump_enable(pump_enable), .gate_bias_enable(gate_bias_enable),
    .gate_bias_ready_flag(gate_bias_ready_flag),
    .drivers_enable(drivers_enable), .host_ldo_enable(host_ldo_enable),
    .host_ldo_pulldown(host_ldo_pulldown),
    .messaging_enable(messaging_enable), .fault_pin_out(fault_pin_out),
    .fault_pin_oe_n(fault_pin_oe_n), .irq(irq));
  link_host_model u_link_host_model (
    .mclk(mclk), .sys_rst(sys_rst), .msg(msg), .msg_ack(msg_ack),
    .gate_bias_ready_flag(gate_bias_ready_flag), .pwm_allowed(pwm_allowed),
    .last_code_ff(last_code), .last_bits_ff(last_bits),
    .msg_cnt_ff(msg_cnt));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk) reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk) reg_req <= '0;
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, logic [7:0] e);
    @(posedge mclk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) reg_req <= '0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic toggle_oe();
    cyc(1);
    oe_pin <= 1'b0;
    cyc(3);
    oe_pin <= 1'b1;
    cyc(14);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3000);
    mismatches++;
    close_out();
  end
  initial begin
    {mclk, sys_rst, oe_pin, sleep_request, wake_event} = 5'h08;
    sense = '0;
    reg_req = '0;
    rows = '{'{BASE, 5'h1F, 8'h00, 8'h00, 8'h00, 8'h00},
             '{11'h54A, 5'h00, 8'h09, 8'h00, 8'h85, 8'h09},
             '{11'h30A, 5'h0F, 8'h00, 8'h00, 8'h00, 8'h00},
             '{11'h32A, 5'h02, 8'h11, 8'h00, 8'h85, 8'h11},
             '{11'h58A, 5'h02, 8'h01, 8'h01, 8'h86, 8'h01}};
    cyc(16);
    #1 chk("rst", {fault_line, drivers_enable, msg.valid}, 3'h0);
    cyc(1);
    sys_rst <= 1'b0;
    sense <= 11'h40A;
    cyc(10);
    rdc("standby", ADDR_STATE, 8'h02);
    chk("sb_bias", gate_bias_enable, 1'b0);
    cyc(1);
    oe_pin <= 1'b1;
    cyc(3);
    rdc("gate", ADDR_STATE, 8'h04);
    chk("pwm_off", pwm_allowed, 1'b0);
    cyc(30);
    rdc("timeout", ADDR_STATE, 8'h08);
    cyc(1);
    sense <= BASE;
    cyc(8);
    rdc("ready", ADDR_CTRL, 8'h01);
    chk("pwm_on", pwm_allowed, 1'b1);
    $display("test bringup done");
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      sense <= rows[i].s;
      cyc(12);
      #1 chk("outs", {pump_enable, gate_bias_enable, drivers_enable,
             host_ldo_enable, fault_line}, rows[i].o);
      rdc("stat0", ADDR_STATUS0, rows[i].s0);
      rdc("second_status_register", ADDR_STATUS1, rows[i].s1);
      if (rows[i].c !== 8'h00)
        chk("msg", {last_code, last_bits}, {rows[i].c, rows[i].b});
      cyc(1);
      sense <= BASE;
      cyc(8);
      toggle_oe();
      $display("test row %0d done", i);
    end
    wr(ADDR_IRQ_ST, 8'h3F);
    wr(ADDR_IRQ_MSK, 8'h00);
    sense <= 11'h32A;
    cyc(12);
    n = msg_cnt;
    toggle_oe();
    rdc("held", ADDR_STATUS0, 8'h11);
    chk("no_msg", msg_cnt, n);
    chk("irq_mask", irq, 1'b0);
    wr(ADDR_IRQ_MSK, 8'h04);
    cyc(2);
    #1 chk("irq_on", irq, 1'b1);
    wr(ADDR_IRQ_ST, 8'h04);
    cyc(2);
    #1 chk("irq_clr", irq, 1'b0);
    cyc(1);
    sense <= BASE;
    cyc(8);
    toggle_oe();
    rdc("cleared", ADDR_STATUS0, 8'h00);
    cyc(1);
    sense <= 11'h52A;
    cyc(2);
    sense <= BASE;
    cyc(10);
    rdc("glitch", ADDR_STATUS0, 8'h00);
    rdc("unmapped", 4'hF, 8'h00);
    $display("test sticky done");
    cyc(1);
    sense <= 11'h50B;
    cyc(14);
    #1 chk("warn", {drivers_enable, fault_line, last_code, last_bits},
           18'h38502);
    cyc(1);
    sense <= 11'h50C;
    cyc(14);
    #1 chk("ot_off", {pump_enable, gate_bias_enable, drivers_enable},
           3'h0);
    chk("ot_msg", {last_code, last_bits}, 16'h8505);
    cyc(1);
    oe_pin <= 1'b0;
    cyc(4);
    #1 chk("ot_quiet", messaging_enable, 1'b0);
    cyc(1);
    sense <= BASE;
    cyc(20);
    #1 chk("ot_hold", drivers_enable, 1'b0);
    cyc(1);
    oe_pin <= 1'b1;
    cyc(40);
    #1 chk("ot_resume", drivers_enable, 1'b1);
    $display("test thermal done");
    cyc(1);
    sleep_request <= 1'b1;
    oe_pin <= 1'b0;
    cyc(30);
    #1 chk("sleep", {host_ldo_enable, host_ldo_pulldown, gate_bias_enable},
           3'h2);
    cyc(1);
    wake_event <= 1'b1;
    sleep_request <= 1'b0;
    cyc(1);
    wake_event <= 1'b0;
    cyc(20);
    #1 chk("wake", {host_ldo_enable, host_ldo_pulldown}, 2'h2);
    cyc(1);
    sense <= 11'h552;
    cyc(12);
    #1 chk("col", {host_ldo_enable, host_ldo_pulldown}, 2'h1);
    rdc("col_st", ADDR_STATE, 8'h20);
    rdc("col_flag", ADDR_STATUS1, 8'h02);
    cyc(1);
    sense <= 11'h542;
    cyc(12);
    rdc("latched", ADDR_STATE, 8'h20);
    cyc(1);
    sense <= BASE;
    cyc(20);
    rdc("restart", ADDR_STATE, 8'h02);
    $display("test collapse done");
    close_out();
  end
endmodule // bias_supply_supervisor_tb_top
bind bias_supply_supervisor bias_supply_supervisor_properties #(
  .GATE_TIMEOUT(GATE_TIMEOUT), .STANDBY_WAIT(STANDBY_WAIT)) u_props (
  .mclk(mclk), .sys_rst(sys_rst), .sense(sense), .msg(msg),
  .msg_ack(msg_ack), .pump_enable(pump_enable),
  .gate_bias_enable(gate_bias_enable),
  .gate_bias_ready_flag(gate_bias_ready_flag),
  .drivers_enable(drivers_enable), .host_ldo_enable(host_ldo_enable),
  .host_ldo_pulldown(host_ldo_pulldown), .fault_pin_oe_n(fault_pin_oe_n));
`default_nettype wire

//--- test/link_host_model.sv
// host partner: acks link messages, prompt and slow in turn
// assumes msg stands until a one-cycle msg_ack
`default_nettype none
module link_host_model
  import bias_supervisor_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire link_msg_type msg,
  input  wire logic         gate_bias_ready_flag,
  output logic              msg_ack,
  output logic              pwm_allowed,
  output logic [7:0]        last_code_ff,
  output logic [7:0]        last_bits_ff,
  output logic [7:0]        msg_cnt_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  logic       ack_ff;
  assign msg_ack = ack_ff;
  assign pwm_allowed = gate_bias_ready_flag;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      wait_ff <= 2'h0;
      msg_cnt_ff <= 8'h00;
    end else if (ack_ff) begin
      ack_ff <= 1'b0;
      wait_ff <= 2'h0;
    end else if (msg.valid) begin
      if (wait_ff == {2{msg_cnt_ff[0]}}) begin
        ack_ff <= 1'b1;
        last_code_ff <= msg.code;
        last_bits_ff <= msg.bits;
        msg_cnt_ff <= msg_cnt_ff + 8'h01;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule // link_host_model
`default_nettype wire
